/* File: src/spfc_ctrl.sv */
// Self-programming flash control: control/status register and sequencer
// Assumes a CPU core issuing store/load strobes and a flash macro done pulse
//
// Operation
// [RULE1] Fuse 1 gives application reset, 0 boot
// [RULE2] Fuses are read only from this side
// [RULE3] Ready interrupt while enabled and command bit clear
// [RULE4] Erase/write to concurrent section sets busy flag
// [RULE5] Busy clears on read enable or buffer load
// [RULE6] Bit five always reads zero
// [RULE7] Read enable plus store re-enables section reads
// [RULE8] Read enable during loading discards the buffer
// [RULE9] Lock set plus store programs boot lock bits
// [RULE10] Load within three cycles returns lock/fuse byte
// [RULE11] Page write plus store writes buffered page
// [RULE12] Halting section operation stalls the CPU
// [RULE13] Page erase plus store erases addressed page
// [RULE14] Command bit alone stores word into buffer
// [RULE15] Command bit arms four cycles, held while busy
// [RULE16] Only five control patterns take effect
// [RULE17] Pointer built from low, high, extension bytes
// [RULE18] Target address latched at operation start
// [RULE19] Software uses same page for erase, write
// [RULE20] Loads address bytes using pointer bits zero and one
// [RULE21] Software enters boot loader by jump
// [RULE22] Concurrent section programming keeps CPU running
// [RULE23] EEPROM write blocks programming and fuse reads
// [RULE24] Window counted in clocks, reset clears all
`timescale 1ns/10ps
`include "spfc_params.svh"
module spfc_ctrl #(
    parameter int          PAGE_W     = 7,
    parameter logic        EXT_EN     = 1'b1,
    parameter logic [23:0] HALTING_SECTION_START = 24'h01_E000,
    parameter logic [23:0] BOOT_RESET = 24'h00_F000
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 csr_we,
    input  wire logic [7:0]           csr_wdata,
    output logic      [7:0]           csr_rdata,
    input  wire logic                 ext_we,
    input  wire logic [7:0]           ext_wdata,
    output logic      [7:0]           ext_rdata,
    input  wire spfc_pkg::spfc_cpu_t  cpu,
    input  wire logic                 global_int_en,
    input  wire logic                 eeprom_busy,
    input  wire logic                 boot_vector_fuse,
    input  wire logic [7:0]           fuse_low,
    input  wire logic [7:0]           fuse_high,
    input  wire logic [7:0]           lock_bits,
    input  wire logic                 flash_done,
    input  wire logic [PAGE_W-1:0]    buf_rd_idx,
    output logic      [15:0]          buf_rd_data,
    output spfc_pkg::spfc_flash_t     flash,
    output logic                      ready_irq,
    output logic                      cpu_stall,
    output logic                      section_busy,
    output logic      [7:0]           rdback_data,
    output logic                      rdback_valid,
    output logic      [23:0]          reset_vector
);
    import spfc_pkg::*;

    typedef struct packed {
        spfc_state_t fsm;
        logic        ie;
        logic        sbusy;
        logic [4:0]  cmd;
        logic [2:0]  cnt;
        logic        stall;
        logic [7:0]  ext;
        spfc_flash_t fl;
        logic [7:0]  rb_data;
        logic        rb_valid;
        logic [23:0] rvec;
    } spfc_regs_t;

    spfc_regs_t s_q;
    spfc_regs_t s_d;

    logic        buf_wr;
    logic        buf_clr;
    logic        buf_loading;
    logic [23:0] zptr;
    logic        wr_ok;
    logic        store_ok;
    logic        load_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic pat_valid(input logic [4:0] p);
        return (p == `SPFC_PAT_RE) || (p == `SPFC_PAT_LS) || (p == `SPFC_PAT_PW)
            || (p == `SPFC_PAT_PE) || (p == `SPFC_PAT_LD);
    endfunction

    assign zptr     = {EXT_EN ? s_q.ext : 8'h00, cpu.ptr_high, cpu.ptr_low}; // RULE17
    assign wr_ok    = csr_we && pat_valid(csr_wdata[4:0]) && !eeprom_busy // RULE16 RULE23
                      && (s_q.fsm == SPFC_IDLE || s_q.fsm == SPFC_ARMED);
    assign store_ok = (s_q.fsm == SPFC_ARMED) && cpu.store && (s_q.cnt != 3'h0);
    assign load_ok  = (s_q.fsm == SPFC_ARMED) && cpu.load && !eeprom_busy
                      && (s_q.cmd == `SPFC_PAT_LS)
                      && (s_q.cnt > `SPFC_STORE_WIN - `SPFC_LOAD_WIN); // RULE10
    assign buf_wr   = store_ok && (s_q.cmd == `SPFC_PAT_LD); // RULE14
    assign buf_clr  = (wr_ok && csr_wdata[4:0] == `SPFC_PAT_RE) // RULE8
                      || (s_q.fsm == SPFC_BUSY && flash_done
                          && s_q.fl.kind == SPFC_OP_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        s_d          = s_q;
        s_d.fl.start = 1'b0;
        s_d.rb_valid = 1'b0;
        s_d.rvec     = boot_vector_fuse ? `SPFC_APP_RESET : BOOT_RESET; // RULE1 RULE2
        if (ext_we && EXT_EN) begin
            s_d.ext = ext_wdata;
        end
        if (csr_we) begin
            s_d.ie = csr_wdata[`SPFC_BIT_IE];
        end
        case (s_q.fsm)
            SPFC_IDLE, SPFC_ARMED: begin
                if (s_q.cnt != 3'h0) begin
                    s_d.cnt = s_q.cnt - 3'h1; // RULE24
                end
                if (s_q.fsm == SPFC_ARMED && s_q.cnt == 3'h1 && !store_ok) begin
                    s_d.fsm = SPFC_IDLE; // RULE15
                    s_d.cmd = `SPFC_PAT_NONE;
                end
                if (load_ok) begin
                    s_d.rb_valid = 1'b1;
                    s_d.fsm      = SPFC_IDLE;
                    s_d.cmd      = `SPFC_PAT_NONE;
                    s_d.cnt      = 3'h0;
                    if (cpu.ptr_low[0] == 1'b0) begin // RULE20
                        s_d.rb_data = fuse_low;
                    end else if (cpu.ptr_low[`SPFC_ZSEL_W-1:0] == `SPFC_ZSEL_FHI) begin
                        s_d.rb_data = fuse_high;
                    end else begin
                        s_d.rb_data = lock_bits;
                    end
                end else if (store_ok) begin
                    s_d.fsm = SPFC_IDLE; // RULE15
                    s_d.cmd = `SPFC_PAT_NONE;
                    s_d.cnt = 3'h0;
                    if (s_q.cmd == `SPFC_PAT_RE) begin
                        s_d.sbusy = 1'b0; // RULE7 RULE5
                    end else if (s_q.cmd == `SPFC_PAT_LD) begin
                        s_d.sbusy = 1'b0; // RULE5
                    end else if (s_q.cmd == `SPFC_PAT_LS) begin
                        s_d.fsm          = SPFC_LOCKP; // RULE9
                        s_d.cmd          = s_q.cmd;
                        s_d.fl.start     = 1'b1;
                        s_d.fl.kind      = SPFC_OP_LOCK;
                        s_d.fl.lock_data = cpu.gpr_zero;
                    end else begin
                        s_d.fsm      = SPFC_BUSY; // RULE11 RULE13
                        s_d.cmd      = s_q.cmd;
                        s_d.fl.start = 1'b1;
                        s_d.fl.kind  = (s_q.cmd == `SPFC_PAT_PW) ? SPFC_OP_WRITE
                                                                 : SPFC_OP_ERASE;
                        s_d.fl.addr  = {zptr[23:PAGE_W+1], {(PAGE_W + 1){1'b0}}}; // RULE18
                        if (zptr >= HALTING_SECTION_START) begin
                            s_d.stall = 1'b1; // RULE12
                        end else begin
                            s_d.sbusy = 1'b1; // RULE4 RULE22
                        end
                    end
                end
                if (wr_ok) begin
                    s_d.fsm = SPFC_ARMED;
                    s_d.cmd = csr_wdata[4:0];
                    s_d.cnt = `SPFC_STORE_WIN;
                end
            end
            SPFC_BUSY, SPFC_LOCKP: begin
                if (flash_done) begin
                    s_d.fsm   = SPFC_IDLE; // RULE15
                    s_d.cmd   = `SPFC_PAT_NONE;
                    s_d.stall = 1'b0;
                end
            end
            default: begin
                s_d.fsm = SPFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q          <= '0; // RULE24
            s_q.fsm      <= SPFC_IDLE;
            s_q.fl.kind  <= SPFC_OP_ERASE;
            s_q.rvec     <= `SPFC_APP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page buffer and outputs

    spfc_page_buffer #(
        .PAGE_W (PAGE_W),
        .DATA_W (16)
    ) u_buf (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (buf_wr),
        .wr_idx  (zptr[PAGE_W:1]),
        .wr_data ({cpu.gpr_one, cpu.gpr_zero}),
        .clr     (buf_clr),
        .rd_idx  (buf_rd_idx),
        .rd_data (buf_rd_data),
        .loading (buf_loading)
    );

    assign csr_rdata    = {s_q.ie, s_q.sbusy, 1'b0, s_q.cmd}; // RULE6
    assign ext_rdata    = s_q.ext;
    assign flash        = s_q.fl;
    assign ready_irq    = s_q.ie && global_int_en && !s_q.cmd[`SPFC_BIT_EN]; // RULE3
    assign cpu_stall    = s_q.stall;
    assign section_busy = s_q.sbusy;
    assign rdback_data  = s_q.rb_data;
    assign rdback_valid = s_q.rb_valid;
    assign reset_vector = s_q.rvec;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_irq;
        @(posedge clk) disable iff (rst)
        (s_q.fsm == SPFC_BUSY) |-> !ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("ready irq during busy op"); // RULE3

    property p_rsv;
        @(posedge clk) disable iff (rst)
        csr_we |=> (csr_rdata[`SPFC_BIT_RSV] == 1'b0);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit reads one"); // RULE6

    property p_busy_set;
        @(posedge clk) disable iff (rst)
        flash.start && flash.kind != SPFC_OP_LOCK && !cpu_stall
        |-> section_busy && csr_rdata[`SPFC_BIT_SB];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy flag not set"); // RULE4

    property p_load_clr;
        @(posedge clk) disable iff (rst)
        buf_wr |=> !section_busy;
    endproperty
    a_load_clr: assert property (p_load_clr) else $error("busy kept after load"); // RULE5

    property p_window;
        @(posedge clk) disable iff (rst)
        (wr_ok && csr_wdata[4:0] == `SPFC_PAT_LD) ##1 (!cpu.store && !csr_we)[*4]
        |=> !csr_rdata[`SPFC_BIT_EN];
    endproperty
    a_window: assert property (p_window) else $error("arming outlived window"); // RULE15

    property p_stall;
        @(posedge clk) disable iff (rst)
        cpu_stall && !flash_done |=> cpu_stall && csr_rdata[`SPFC_BIT_EN];
    endproperty
    a_stall: assert property (p_stall) else $error("stall dropped early"); // RULE12

    property p_abort;
        @(posedge clk) disable iff (rst)
        wr_ok && csr_wdata[4:0] == `SPFC_PAT_RE |=> !buf_loading;
    endproperty
    a_abort: assert property (p_abort) else $error("buffer kept after abort"); // RULE8

    property p_latch;
        @(posedge clk) disable iff (rst)
        (s_q.fsm == SPFC_BUSY) && !flash_done |=> $stable(flash.addr);
    endproperty
    a_latch: assert property (p_latch) else $error("address moved mid op"); // RULE18

    property p_rdback;
        @(posedge clk) disable iff (rst)
        rdback_valid |-> $past(cpu.load) && !$past(eeprom_busy);
    endproperty
    a_rdback: assert property (p_rdback) else $error("readback without load"); // RULE10

    property p_rvec;
        @(posedge clk) disable iff (rst)
        !boot_vector_fuse |=> (reset_vector == BOOT_RESET);
    endproperty
    a_rvec: assert property (p_rvec) else $error("wrong reset vector"); // RULE1

    c_erase: cover property (@(posedge clk) flash.start && flash.kind == SPFC_OP_ERASE);
    c_stall: cover property (@(posedge clk) cpu_stall);
    c_rdback: cover property (@(posedge clk) rdback_valid);
endmodule

/* File: src/spfc_page_buffer.sv */
// Temporary page buffer, one 16-bit word per page slot
// Assumes writes and clears come from the flash control sequencer
`timescale 1ns/10ps
module spfc_page_buffer #(
    parameter int PAGE_W = 7,
    parameter int DATA_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              wr_en,
    input  wire logic [PAGE_W-1:0] wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              clr,
    input  wire logic [PAGE_W-1:0] rd_idx,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   loading
);
    localparam int WORDS = 1 << PAGE_W;
    typedef struct packed {
        logic [WORDS-1:0][DATA_W-1:0] mem;
        logic                         loading;
    } spfc_buf_t;

    spfc_buf_t s_q;
    spfc_buf_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr) begin
            s_d = '0;
        end else if (wr_en) begin
            s_d.mem[wr_idx] = wr_data;
            s_d.loading     = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.mem[rd_idx];
    assign loading = s_q.loading;
endmodule

/* File: src/spfc_params.svh */
// Constants of the self-programming flash control block
// Assumes inclusion by bare name from the control sequencer design file
`ifndef SPFC_PARAMS_SVH
`define SPFC_PARAMS_SVH
`define SPFC_BIT_IE     7
`define SPFC_BIT_SB     6
`define SPFC_BIT_RSV    5
`define SPFC_BIT_EN     0
`define SPFC_CSR_RESET  8'h00
`define SPFC_PAT_RE     5'h11
`define SPFC_PAT_LS     5'h09
`define SPFC_PAT_PW     5'h05
`define SPFC_PAT_PE     5'h03
`define SPFC_PAT_LD     5'h01
`define SPFC_PAT_NONE   5'h00
`define SPFC_STORE_WIN  3'h4
`define SPFC_LOAD_WIN   3'h3
`define SPFC_APP_RESET  24'h00_0000
`define SPFC_ZSEL_W     2
`define SPFC_ZSEL_LOCK  2'h1
`define SPFC_ZSEL_FHI   2'h3
`endif

/* File: src/spfc_pkg.sv */
// Types shared by the self-programming flash control block
// Assumes spfc_params.svh is on the include path
package spfc_pkg;
    typedef enum logic [3:0] {
        SPFC_IDLE  = 4'b0001,
        SPFC_ARMED = 4'b0010,
        SPFC_BUSY  = 4'b0100,
        SPFC_LOCKP = 4'b1000
    } spfc_state_t;

    typedef enum logic [1:0] {
        SPFC_OP_ERASE = 2'h0,
        SPFC_OP_WRITE = 2'h1,
        SPFC_OP_LOCK  = 2'h2
    } spfc_op_t;

    typedef struct packed {
        logic        store;
        logic        load;
        logic [7:0]  gpr_zero;
        logic [7:0]  gpr_one;
        logic [7:0]  ptr_high;
        logic [7:0]  ptr_low;
    } spfc_cpu_t;

    typedef struct packed {
        logic        start;
        spfc_op_t    kind;
        logic [23:0] addr;
        logic [7:0]  lock_data;
    } spfc_flash_t;
endpackage

/* File: tb/spfc_flash_model.sv */
// Flash macro stand-in: answers each start pulse with one done pulse
// Assumes lat is held steady by the bench while an operation runs
`timescale 1ns/10ps
module spfc_flash_model (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire spfc_pkg::spfc_flash_t flash,
    input  wire logic [3:0]            lat,
    output logic                       flash_done
);
    import spfc_pkg::*;
    logic [3:0] cnt_q;
    logic       run_q;
    ////////////////////////////////////////////////////////////////
    // Busy time, short or long as the bench asks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            run_q <= 1'b0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= 1'b0;
            if (flash.start) begin
                cnt_q <= lat;
                run_q <= 1'b1;
            end else if (run_q && cnt_q == 4'h0) begin
                run_q <= 1'b0;
                flash_done <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench of the flash control sequencer
// Assumes spfc_pkg compiled first and spfc_flash_model as flash macro
`timescale 1ns/10ps
module tb_top;
    import spfc_pkg::*;
    localparam logic [23:0] BOOT_RESET = 24'h00_F000;
    logic        clk, rst, csr_we, ext_we, gie, ee_busy, fuse, flash_done;
    logic [7:0]  csr_wdata, csr_rdata, ext_wdata, ext_rdata, rd_data;
    logic [7:0]  fuse_low, fuse_high, lock_bits, g0, pl;
    logic [6:0]  buf_rd_idx;
    logic [15:0] buf_rd_data, d;
    logic        ready_irq, cpu_stall, section_busy, rd_valid;
    logic [23:0] reset_vector;
    logic [3:0]  lat;
    spfc_cpu_t   cpu;
    spfc_flash_t flash, mon_e;
    int          errors, comparisons, cycles;
    spfc_flash_t exp_op[$];
    logic [7:0]  exp_rd[$];
    logic [7:0]  pats[5] = '{8'h3F, 8'h07, 8'h02, 8'h13, 8'h0D};

    spfc_ctrl dut (.clk(clk), .rst(rst), .csr_we(csr_we), .csr_wdata(csr_wdata),
        .csr_rdata(csr_rdata), .ext_we(ext_we), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .cpu(cpu), .global_int_en(gie), .eeprom_busy(ee_busy),
        .boot_vector_fuse(fuse), .fuse_low(fuse_low), .fuse_high(fuse_high),
        .lock_bits(lock_bits), .flash_done(flash_done), .buf_rd_idx(buf_rd_idx),
        .buf_rd_data(buf_rd_data), .flash(flash), .ready_irq(ready_irq),
        .cpu_stall(cpu_stall), .section_busy(section_busy), .rdback_data(rd_data),
        .rdback_valid(rd_valid), .reset_vector(reset_vector));
    spfc_flash_model fm (.clk(clk), .rst(rst), .flash(flash), .lat(lat),
        .flash_done(flash_done));

    ////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic csr_wr(logic [7:0] v);
        @(negedge clk);
        csr_we = 1'b1;
        csr_wdata = v;
        @(negedge clk);
        csr_we = 1'b0;
    endtask
    task automatic ext_wr(logic [7:0] v);
        @(negedge clk);
        ext_we = 1'b1;
        ext_wdata = v;
        @(negedge clk);
        ext_we = 1'b0;
        check("ext", ext_rdata, v);
    endtask
    task automatic strobe(logic st, logic [7:0] r0, r1, ph, p);
        cpu = '{st, !st, r0, r1, ph, p};
        @(negedge clk);
        cpu = '{1'b0, 1'b0, r0, r1, 8'($urandom), 8'($urandom)};
    endtask
    task automatic op(logic [7:0] pat, spfc_op_t k, logic [7:0] ph, p);
        g0 = 8'($urandom);
        lat = 4'(6 + $urandom % 10);
        exp_op.push_back('{1'b1, k, {ext_rdata, ph, 8'h00}, g0});
        csr_wr(pat);
        strobe(1'b1, g0, 8'($urandom), ph, p);
        @(negedge clk);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 40 && csr_rdata[0] !== 1'b0; i++) @(negedge clk);
        check("cmd idle", csr_rdata[0], 0);
    endtask
    task automatic buf_load;
        d = 16'($urandom);
        buf_rd_idx = 7'($urandom);
        csr_wr(8'h01);
        strobe(1'b1, d[7:0], d[15:8], 8'($urandom), {buf_rd_idx, 1'b1});
        check("buffer", buf_rd_data, d);
    endtask

    ////////////////////////////////////////////////////////////////
    // Monitor: each start or readback takes the oldest note
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
        if (!rst && flash.start === 1'b1) begin
            mon_e = exp_op.pop_front();
            check("kind", flash.kind, mon_e.kind);
            if (mon_e.kind == SPFC_OP_LOCK) check("lock", flash.lock_data, mon_e.lock_data);
            else check("addr", flash.addr, mon_e.addr);
        end
        if (!rst && rd_valid === 1'b1) check("rdback", rd_data, exp_rd.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        void'($urandom(69));
        {csr_we, csr_wdata, ext_we, ext_wdata, ee_busy, buf_rd_idx, lat} = '0;
        {rst, gie, fuse, cpu} = {3'b111, 34'h0};
        {fuse_low, fuse_high, lock_bits} = 24'($urandom);
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("reset_vector", reset_vector, 24'h00_0000);
        check("csr", csr_rdata, 8'h00);
        buf_load();
        check("cmd", csr_rdata[0], 0);
        foreach (pats[i]) begin
            csr_wr(pats[i]);
            check("csr", csr_rdata, 8'h00);
        end
        csr_wr(8'hA1);
        check("irq", ready_irq, 0);
        check("csr", csr_rdata, 8'h81);
        repeat (3) @(negedge clk);
        check("cmd", csr_rdata[0], 1);
        @(negedge clk);
        check("irq", ready_irq, 1);
        gie = 1'b0;
        @(negedge clk);
        check("irq", ready_irq, 0);
        gie = 1'b1;
        for (int z = 0; z < 4; z++) begin
            pl = 8'($urandom) & 8'hFC | 8'(z);
            exp_rd.push_back(z == 1 ? lock_bits : z == 3 ? fuse_high : fuse_low);
            csr_wr(8'h09);
            strobe(1'b0, 8'h00, 8'h00, 8'h00, pl);
        end
        ee_busy = 1'b1;
        csr_wr(8'h09);
        check("csr", csr_rdata, 8'h00);
        strobe(1'b0, 8'h00, 8'h00, 8'h00, 8'h01);
        ee_busy = 1'b0;
        ext_wr(8'h01);
        op(8'h03, SPFC_OP_ERASE, 8'hE4, 8'h57);
        check("stall", cpu_stall, 1);
        check("cmd", csr_rdata[0], 1);
        wait_idle();
        check("stall", cpu_stall, 0);
        ext_wr(8'h00);
        op(8'h05, SPFC_OP_WRITE, 8'h12, 8'h34);
        check("busy", section_busy, 1);
        check("csr busy", csr_rdata[6], 1);
        check("stall", cpu_stall, 0);
        csr_wr(8'h11);
        strobe(1'b1, 8'h00, 8'h00, 8'h00, 8'h00);
        wait_idle();
        check("busy", section_busy, 1);
        csr_wr(8'h11);
        strobe(1'b1, 8'h00, 8'h00, 8'h00, 8'h00);
        check("busy", section_busy, 0);
        op(8'h03, SPFC_OP_ERASE, 8'h20, 8'h00);
        wait_idle();
        buf_load();
        check("busy", section_busy, 0);
        op(8'h09, SPFC_OP_LOCK, 8'h00, 8'h01);
        wait_idle();
        buf_load();
        csr_wr(8'h11);
        check("abort", buf_rd_data, 16'h0000);
        buf_load();
        fuse = 1'b0;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("reset buffer", buf_rd_data, 16'h0000);
        check("reset_vector", reset_vector, BOOT_RESET);
        check("pending", exp_op.size() + exp_rd.size(), 0);
        test_done();
    end
endmodule
